/* File: src/gyro_fmt_pkg.sv */
package gyro_fmt_pkg;
	localparam int RATE_W = 24;
	localparam int ANGLE_W = 24;
	localparam int TEMP_W = 16;
	localparam int SCNT_W = 8;
	localparam int LAT_W = 16;
	localparam int SHIFT_W = 4;
	localparam int LP_FRAC_W = 15;
	localparam int RATE_FRAC_BITS = 14;
	localparam int ANGLE_FRAC_BITS = 21;
	localparam int SAMPLE_RATE_HZ = 2000;
	localparam int ANGLE_MUL = 2 ** (ANGLE_FRAC_BITS - RATE_FRAC_BITS);
	localparam int ANGLE_DIV = SAMPLE_RATE_HZ;
	localparam int CLK_HZ = 100_000_000;
	localparam int US_PER_S = 1_000_000;
	localparam int CYC_PER_US = CLK_HZ / US_PER_S;
	localparam int DEF_MAX_SAMPLES = 2000;
	localparam logic [LAT_W-1:0] LAT_MAX = 16'hFFFF;

	typedef enum logic [3:0] {
		OUT_RATE = 4'h1,
		OUT_INCR = 4'h2,
		OUT_AVG = 4'h4,
		OUT_INTEG = 4'h8
	} out_mode_type;

	typedef struct packed {
		logic [7:0] high_byte;
		logic [7:0] middle_byte;
		logic [7:0] low_byte;
	} word24_type;

	typedef struct packed {
		logic [7:0] high_byte;
		logic [7:0] low_byte;
	} word16_type;

	typedef struct packed {
		word24_type value;
		word16_type temperature;
	} axis_field_type;
endpackage : gyro_fmt_pkg

/* File: src/gyro_axis_lowpass.sv */
`timescale 1ns/1ns
`default_nettype none
module gyro_axis_lowpass import gyro_fmt_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_vld,
	input wire logic signed [RATE_W-1:0] i_rate,
	input wire logic [SHIFT_W-1:0] i_shift,
	output logic o_vld,
	output logic signed [RATE_W-1:0] o_rate
);
	localparam int EXT_W = RATE_W + LP_FRAC_W + 1;
	logic signed [EXT_W-1:0] y_ff, nxt_y, x_ext, diff;
	logic vld_ff, nxt_vld;

	if (2 ** SHIFT_W - 1 > LP_FRAC_W) begin : g_bad_shift
		$error("Shift range exceeds filter precision");
	end

	// First-order smoothing; extra fraction bits keep small steps from stalling
	always_comb begin
		x_ext = EXT_W'(i_rate) <<< LP_FRAC_W;
		diff = x_ext - y_ff;
		nxt_y = y_ff;
		nxt_vld = i_vld;
		if (i_vld) begin
			nxt_y = y_ff + (diff >>> i_shift);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			y_ff <= '0;
			vld_ff <= 1'b0;
		end else begin
			y_ff <= nxt_y;
			vld_ff <= nxt_vld;
		end
	end

	assign o_vld = vld_ff;
	assign o_rate = y_ff[LP_FRAC_W +: RATE_W];

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	AST_LP_BYPASS: assert property (i_vld && i_shift == '0 |=> o_vld && o_rate == $past(i_rate))
		else $error("Unfiltered sample not passed through");
endmodule : gyro_axis_lowpass
`default_nettype wire

/* File: src/gyro_axis_accum.sv */
`timescale 1ns/1ns
`default_nettype none
module gyro_axis_accum import gyro_fmt_pkg::*; #(
	parameter int MAX_SAMPLES = DEF_MAX_SAMPLES
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire out_mode_type i_mode,
	input wire logic i_vld,
	input wire logic signed [RATE_W-1:0] i_rate,
	input wire logic i_tx,
	output logic [ANGLE_W-1:0] o_value
);
	localparam int CNT_W = $clog2(MAX_SAMPLES + 1);
	localparam int SUM_W = RATE_W + CNT_W;
	localparam int PROD_W = SUM_W + 12;
	localparam int TOT_W = RATE_W + 14;
	localparam int FRAC_W = $clog2(ANGLE_DIV);

	if (MAX_SAMPLES < 1) begin : g_bad_max
		$error("MAX_SAMPLES must be positive");
	end

	logic signed [SUM_W-1:0] sum_ff, nxt_sum, sum_now, avg_full;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt, cnt_now;
	logic signed [PROD_W-1:0] incr_full;
	logic signed [TOT_W-1:0] tot, quo, rem;
	logic [FRAC_W-1:0] frac_ff, nxt_frac;
	logic [ANGLE_W-1:0] angle_ff, nxt_angle, value_ff, nxt_value;
	logic signed [RATE_W-1:0] last_ff, nxt_last;
	logic take;

	always_comb begin
		// Samples past the cap are dropped so sum and count stay consistent
		take = i_vld && (cnt_ff != CNT_W'(MAX_SAMPLES));
		sum_now = take ? sum_ff + SUM_W'(i_rate) : sum_ff;
		cnt_now = take ? cnt_ff + 1'b1 : cnt_ff;
		incr_full = (PROD_W'(sum_now) * PROD_W'(ANGLE_MUL)) / PROD_W'(ANGLE_DIV);
		avg_full = (cnt_now == '0) ? '0 : sum_now / SUM_W'($signed({1'b0, cnt_now}));
		// Remainder carried so no fraction of the integral is ever lost
		tot = TOT_W'($signed({1'b0, frac_ff})) + TOT_W'(i_rate) * TOT_W'(ANGLE_MUL);
		quo = tot / TOT_W'(ANGLE_DIV);
		rem = tot - quo * TOT_W'(ANGLE_DIV);
		if (rem < 0) begin
			quo = quo - TOT_W'(1);
			rem = rem + TOT_W'(ANGLE_DIV);
		end
		nxt_angle = angle_ff;
		nxt_frac = frac_ff;
		nxt_last = last_ff;
		if (i_vld) begin
			nxt_angle = angle_ff + quo[ANGLE_W-1:0];
			nxt_frac = rem[FRAC_W-1:0];
			nxt_last = i_rate;
		end
		nxt_sum = sum_now;
		nxt_cnt = cnt_now;
		nxt_value = value_ff;
		if (i_tx) begin
			nxt_sum = '0;
			nxt_cnt = '0;
			case (i_mode)
				OUT_INCR: nxt_value = incr_full[ANGLE_W-1:0];
				OUT_AVG: nxt_value = avg_full[ANGLE_W-1:0];
				OUT_INTEG: nxt_value = nxt_angle;
				default: nxt_value = nxt_last;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			sum_ff <= '0;
			cnt_ff <= '0;
			frac_ff <= '0;
			angle_ff <= '0;
			last_ff <= '0;
			value_ff <= '0;
		end else begin
			sum_ff <= nxt_sum;
			cnt_ff <= nxt_cnt;
			frac_ff <= nxt_frac;
			angle_ff <= nxt_angle;
			last_ff <= nxt_last;
			value_ff <= nxt_value;
		end
	end

	assign o_value = value_ff;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	AST_ACC_RESTART: assert property (i_tx ##1 !i_vld |-> sum_ff == '0 && cnt_ff == '0)
		else $error("Accumulation not restarted after transmission");
	AST_INT_KEEP: assert property (i_tx && !i_vld |=> angle_ff == $past(angle_ff))
		else $error("Integrated angle disturbed by transmission");
	AST_AVG_SINGLE: assert property (
		i_tx && i_mode == OUT_AVG && i_vld && cnt_ff == '0 |=> o_value == $past(i_rate))
		else $error("Mean of one sample differs from the sample");
endmodule : gyro_axis_accum
`default_nettype wire

/* File: src/gyro_output_value_formatter.sv */
`timescale 1ns/1ns
`default_nettype none
module gyro_output_value_formatter import gyro_fmt_pkg::*; #(
	parameter int N_AXES = 3,
	parameter int MAX_SAMPLES = DEF_MAX_SAMPLES
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_sample_stb,
	input wire logic [N_AXES-1:0][RATE_W-1:0] i_rate,
	input wire logic [N_AXES-1:0][TEMP_W-1:0] i_temp,
	input wire logic [N_AXES-1:0][SHIFT_W-1:0] i_lp_shift,
	input wire out_mode_type i_mode,
	input wire logic i_trig,
	input wire logic i_tx_stb,
	output axis_field_type [N_AXES-1:0] o_axis,
	output logic [SCNT_W-1:0] o_counter,
	output word16_type o_latency,
	output logic o_valid
);
	if (N_AXES < 1 || N_AXES > 3) begin : g_bad_axes
		$error("N_AXES must be 1 to 3");
	end

	logic [N_AXES-1:0] filt_vld;
	logic [N_AXES-1:0][RATE_W-1:0] filt_rate;
	logic [N_AXES-1:0][ANGLE_W-1:0] value_w;
	logic [N_AXES-1:0][TEMP_W-1:0] temp_ff, nxt_temp;
	logic [SCNT_W-1:0] scnt_ff, nxt_scnt, cnt_out_ff, nxt_cnt_out;
	logic [$clog2(CYC_PER_US)-1:0] div_ff, nxt_div;
	logic [LAT_W-1:0] lat_ff, nxt_lat, lat_out_ff, nxt_lat_out;
	logic tx_d_ff, nxt_tx_d, valid_ff, nxt_valid, us_tick;

	genvar g;
	generate
		for (g = 0; g < N_AXES; g++) begin : g_axis
			gyro_axis_lowpass u_lp (
				.i_sys_clk(i_sys_clk),
				.i_rst_b(i_rst_b),
				.i_vld(i_sample_stb),
				.i_rate(i_rate[g]),
				.i_shift(i_lp_shift[g]),
				.o_vld(filt_vld[g]),
				.o_rate(filt_rate[g])
			);
			// Transmit is delayed one cycle to match the filter stage
			gyro_axis_accum #(.MAX_SAMPLES(MAX_SAMPLES)) u_acc (
				.i_sys_clk(i_sys_clk),
				.i_rst_b(i_rst_b),
				.i_mode(i_mode),
				.i_vld(filt_vld[g]),
				.i_rate(filt_rate[g]),
				.i_tx(tx_d_ff),
				.o_value(value_w[g])
			);
			assign o_axis[g].value = value_w[g];
			assign o_axis[g].temperature = temp_ff[g];
		end
	endgenerate

	always_comb begin
		us_tick = (div_ff == $bits(div_ff)'(CYC_PER_US - 1));
		// Trigger restarts the phase, else latency is off by up to a microsecond
		nxt_div = (us_tick || i_trig) ? '0 : div_ff + 1'b1;
		nxt_scnt = i_sample_stb ? scnt_ff + 1'b1 : scnt_ff;
		nxt_lat = lat_ff;
		if (i_trig) begin
			nxt_lat = '0;
		end else if (us_tick && lat_ff != LAT_MAX) begin
			nxt_lat = lat_ff + 1'b1;
		end
		nxt_tx_d = i_tx_stb;
		nxt_valid = tx_d_ff;
		nxt_temp = temp_ff;
		nxt_cnt_out = cnt_out_ff;
		nxt_lat_out = lat_out_ff;
		if (tx_d_ff) begin
			nxt_temp = i_temp;
			nxt_cnt_out = scnt_ff;
			nxt_lat_out = lat_ff;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			div_ff <= '0;
			scnt_ff <= '0;
			lat_ff <= '0;
			tx_d_ff <= 1'b0;
			valid_ff <= 1'b0;
			temp_ff <= '0;
			cnt_out_ff <= '0;
			lat_out_ff <= '0;
		end else begin
			div_ff <= nxt_div;
			scnt_ff <= nxt_scnt;
			lat_ff <= nxt_lat;
			tx_d_ff <= nxt_tx_d;
			valid_ff <= nxt_valid;
			temp_ff <= nxt_temp;
			cnt_out_ff <= nxt_cnt_out;
			lat_out_ff <= nxt_lat_out;
		end
	end

	assign o_counter = cnt_out_ff;
	assign o_latency = lat_out_ff;
	assign o_valid = valid_ff;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_tx_taken;
		i_tx_stb ##1 tx_d_ff;
	endsequence

	AST_CNT_STEP: assert property (i_sample_stb |=> scnt_ff == $past(scnt_ff) + 8'h01)
		else $error("Sample counter did not step by one");
	AST_VALID_TIMING: assert property (s_tx_taken |=> o_valid)
		else $error("Fields not presented two cycles after transmit");
	AST_TEMP_CAPTURE: assert property (tx_d_ff |=> o_axis[0].temperature == $past(i_temp[0]))
		else $error("Temperature not captured at transmit");
	AST_LAT_RESET: assert property (i_trig ##1 (!i_trig && !us_tick) |=> lat_ff == '0)
		else $error("Latency not restarted by trigger");
endmodule : gyro_output_value_formatter
`default_nettype wire

/* File: dv/gyro_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module gyro_host_model import gyro_fmt_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_valid,
	input wire axis_field_type i_axis,
	input wire logic [SCNT_W-1:0] i_counter,
	input wire word16_type i_latency,
	output var axis_field_type o_axis,
	output var logic [SCNT_W-1:0] o_counter,
	output var word16_type o_latency,
	output var int o_count
);
	// Fields are only trusted on the one-cycle valid pulse
	initial o_count = 0;
	always @(posedge i_sys_clk) begin
		if (i_valid === 1'b1) begin
			o_axis <= i_axis;
			o_counter <= i_counter;
			o_latency <= i_latency;
			o_count <= o_count + 1;
		end
	end
endmodule : gyro_host_model
`default_nettype wire

/* File: dv/gyro_output_value_formatter_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module gyro_output_value_formatter_tb import gyro_fmt_pkg::*; ;
	logic sys_clk, rst_b, stb, trig, tx, valid;
	logic [0:0][RATE_W-1:0] rate;
	logic [0:0][TEMP_W-1:0] temp;
	logic [0:0][SHIFT_W-1:0] shift;
	out_mode_type mode;
	axis_field_type [0:0] axis;
	axis_field_type h_axis;
	logic [SCNT_W-1:0] cnt, h_cnt;
	word16_type lat, h_lat;
	int h_n;
	int fails = 0;
	int samples_checked = 0;
	int ns = 0;
	int cyc = 0;

	gyro_output_value_formatter #(.N_AXES(1)) DUT (.i_sys_clk(sys_clk), .i_rst_b(rst_b),
		.i_sample_stb(stb), .i_rate(rate), .i_temp(temp), .i_lp_shift(shift), .i_mode(mode),
		.i_trig(trig), .i_tx_stb(tx), .o_axis(axis), .o_counter(cnt), .o_latency(lat),
		.o_valid(valid));
	gyro_host_model host (.i_sys_clk(sys_clk), .i_valid(valid), .i_axis(axis[0]),
		.i_counter(cnt), .i_latency(lat), .o_axis(h_axis), .o_counter(h_cnt),
		.o_latency(h_lat), .o_count(h_n));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task test_done();
		$display("Checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	// Hang guard, far above the roughly 5000 cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			test_done();
		end
	end

	task chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task smp(input logic [23:0] r);
		@(posedge sys_clk);
		stb <= 1'b1;
		rate[0] <= r;
		ns++;
		@(posedge sys_clk);
		stb <= 1'b0;
	endtask : smp

	task send();
		int n0;
		int w;
		n0 = h_n;
		w = 0;
		@(posedge sys_clk);
		tx <= 1'b1;
		@(posedge sys_clk);
		tx <= 1'b0;
		// Host count moves one edge after the pulse, seen here one edge later
		while (w < 8 && h_n == n0) begin
			@(posedge sys_clk);
			w++;
		end
		chk("valid delay", 24'(w), 24'h000003);
		chk("valid pulse", {23'h000000, valid}, 24'h000000);
		chk("counter", h_cnt, ns[7:0]);
		chk("temperature", h_axis.temperature, temp[0]);
	endtask : send

	task t_integ();
		repeat (2) smp(24'h0007D0);
		send();
		chk("integrated", h_axis.value, 24'h000100);
		send();
		chk("integrated kept", h_axis.value, 24'h000100);
		repeat (16) smp(24'h7D0000);
		send();
		chk("integrated wrap", h_axis.value, 24'h800100);
	endtask : t_integ

	task t_rate();
		mode <= OUT_RATE;
		repeat (255) smp(24'h000003);
		smp(24'h000005);
		send();
		chk("rate", h_axis.value, 24'h000005);
	endtask : t_rate

	task t_avg();
		shift[0] <= 4'h1;
		mode <= OUT_AVG;
		repeat (2) smp(24'h0003E8);
		send();
		chk("filtered average", h_axis.value, 24'h000272);
		shift[0] <= 4'h0;
		smp(24'h000064);
		smp(24'h0000C8);
		smp(24'h00012C);
		send();
		chk("average", h_axis.value, 24'h0000C8);
		// Full-scale period stresses accumulator width
		repeat (2000) smp(24'h7FFFFF);
		send();
		chk("average full scale", h_axis.value, 24'h7FFFFF);
	endtask : t_avg

	task t_incr();
		mode <= OUT_INCR;
		send();
		repeat (4) smp(24'h0007D0);
		send();
		chk("incremental", h_axis.value, 24'h000200);
		send();
		chk("incremental empty", h_axis.value, 24'h000000);
	endtask : t_incr

	task t_lat();
		@(posedge sys_clk);
		trig <= 1'b1;
		@(posedge sys_clk);
		trig <= 1'b0;
		repeat (254) @(posedge sys_clk);
		temp[0] <= 16'h1A40;
		send();
		chk("latency", h_lat, 24'h000002);
	endtask : t_lat

	task t_reset();
		@(posedge sys_clk);
		rst_b <= 1'b0;
		mode <= OUT_INTEG;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		ns = 0;
		smp(24'h0007D0);
		send();
		chk("integrated after reset", h_axis.value, 24'h000080);
	endtask : t_reset

	initial begin
		rst_b = 1'b0;
		stb = 1'b0;
		trig = 1'b0;
		tx = 1'b0;
		rate = '0;
		temp[0] = 16'hFE80;
		shift = '0;
		mode = OUT_INTEG;
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_integ();
		t_rate();
		t_avg();
		t_incr();
		t_lat();
		t_reset();
		test_done();
	end
endmodule : gyro_output_value_formatter_tb
`default_nettype wire
